//--- core/lmp_defines.vh
// constants shared by the local memory bus master port
// assumes inclusion by bare name from every core file
`ifndef LMP_DEFINES_VH
`define LMP_DEFINES_VH

// transfer sizes on the request port
`define LMP_SZ_BYTE 2'h0
`define LMP_SZ_HALF 2'h1
`define LMP_SZ_WORD 2'h2

// lane-select patterns, bit 0 is lane 0 (most significant byte)
`define LMP_LANE_NONE 4'h0
`define LMP_LANE_ALL 4'hf
`define LMP_LANE_BYTE_HI 4'h8
`define LMP_LANE_BYTE_LO 4'h1
`define LMP_LANE_HALF_HI 4'hc
`define LMP_LANE_HALF_LO 4'h3

// zero-extension masks for loads
`define LMP_MASK_BYTE 32'h000000ff
`define LMP_MASK_HALF 32'h0000ffff
`define LMP_MASK_WORD 32'hffffffff

// reset values
`define LMP_RST_ADDR 32'h00000000
`define LMP_RST_DATA 32'h00000000

`endif

//--- core/lmp_steer.v
// byte lane steering for data-side loads and stores
// purely combinational; address and size are checked for alignment upstream
`include "lmp_defines.vh"

module lmp_steer (
  bigEndian,
  size,
  addrLow,
  storeVal,
  loadWord,
  laneSel,
  laneData,
  loadVal
);
  input wire bigEndian;
  input wire [1:0] size;
  input wire [1:0] addrLow;
  input wire [0:31] storeVal;
  input wire [0:31] loadWord;
  output reg [0:3] laneSel;
  output reg [0:31] laneData;
  output reg [0:31] loadVal;

  reg [1:0] lane;
  reg [4:0] shamt;

  always @* begin
    lane = 2'h0;
    shamt = 5'h0;
    laneSel = `LMP_LANE_ALL;
    laneData = storeVal;
    loadVal = loadWord;
    case (size)
      `LMP_SZ_BYTE: begin
        lane = bigEndian ? addrLow : (2'h3 - addrLow);
        shamt = {2'h3 - lane, 3'h0};
        laneSel = `LMP_LANE_BYTE_HI >> lane;
        laneData = (storeVal & `LMP_MASK_BYTE) << shamt;
        loadVal = (loadWord >> shamt) & `LMP_MASK_BYTE;
      end
      `LMP_SZ_HALF: begin
        lane = bigEndian ? addrLow : (2'h2 - addrLow);
        shamt = {2'h2 - lane, 3'h0};
        laneSel = (lane == 2'h0) ? `LMP_LANE_HALF_HI : `LMP_LANE_HALF_LO;
        laneData = (storeVal & `LMP_MASK_HALF) << shamt;
        loadVal = (loadWord >> shamt) & `LMP_MASK_HALF;
      end
      default: begin
        laneSel = `LMP_LANE_ALL;
        laneData = storeVal;
        loadVal = loadWord & `LMP_MASK_WORD;
      end
    endcase
  end
endmodule // lmp_steer

//--- core/lmp_fetch.v
// instruction-side fetch port: full-word reads only
// assumes the fetch requester holds fetchValid until fetchReady
`include "lmp_defines.vh"

module lmp_fetch (
  clock,
  sys_rst,
  fetchValid,
  fetchAddr,
  fetchReady,
  fetchRspValid,
  fetchRspWord,
  fetchRspFixedErr,
  fetchRspBadWord,
  instrAddr,
  instrSideStartStrobe,
  fetchBusyFlag,
  instrWord,
  instrSideDone,
  instrSideHold,
  instrFixedErrFlag,
  instrBadWordFlag
);
  input wire clock;
  input wire sys_rst;
  input wire fetchValid;
  input wire [0:31] fetchAddr;
  output wire fetchReady;
  output reg fetchRspValid;
  output reg [0:31] fetchRspWord;
  output reg fetchRspFixedErr;
  output reg fetchRspBadWord;
  output reg [0:31] instrAddr;
  output reg instrSideStartStrobe;
  output reg fetchBusyFlag;
  input wire [0:31] instrWord;
  input wire instrSideDone;
  input wire instrSideHold;
  input wire instrFixedErrFlag;
  input wire instrBadWordFlag;

  wire doneNow;
  wire take;

  assign doneNow = fetchBusyFlag && instrSideDone;
  assign fetchReady = !fetchBusyFlag || instrSideDone;
  assign take = fetchValid && fetchReady;

  always @(posedge clock) begin
    if (sys_rst) begin
      instrAddr <= `LMP_RST_ADDR;
      instrSideStartStrobe <= 1'b0;
      fetchBusyFlag <= 1'b0;
      fetchRspValid <= 1'b0;
      fetchRspWord <= `LMP_RST_DATA;
      fetchRspFixedErr <= 1'b0;
      fetchRspBadWord <= 1'b0;
    end else begin
      instrSideStartStrobe <= take;
      if (take) begin
        instrAddr <= {fetchAddr[0:29], 2'h0};
      end
      if (take) begin
        fetchBusyFlag <= 1'b1;
      end else if (doneNow) begin
        fetchBusyFlag <= 1'b0;
      end
      fetchRspValid <= doneNow;
      if (doneNow) begin
        fetchRspWord <= instrWord;
        fetchRspFixedErr <= instrFixedErrFlag;
        fetchRspBadWord <= instrBadWordFlag;
      end
    end
  end
endmodule // lmp_fetch

//--- core/lmp_master.v
// master port on the single-cycle local memory bus, data and instruction
// sides; assumes one core clock for everything and memory-side
// controllers that answer every started transfer with a done pulse.
//
// Operation
// - address output valid only with start strobe, first cycle only.
// - lane-select outputs valid only with start strobe, first cycle only.
// - lane patterns limited to single bytes, two halfwords, or full word.
// - store data presented with start strobe; memory uses selected lanes only.
// - start strobe high exactly one cycle per transfer, then low.
// - read strobe rises at read start, may last until cycle after done.
// - read strobe stays high across back-to-back reads.
// - write strobe same as read strobe, for writes, back-to-back too.
// - done completes a transfer; next one may start following cycle.
// - all bus activity synchronous to the single core clock.
// - steer narrow accesses; never issue an access wider than target.
// - big-endian lane selection and load steering by low address bits.
// - little-endian lane selection and load steering, mirrored lanes.
// - every bus signal active high.
// - big-endian stores put low byte or halfword on addressed lanes.
// - little-endian stores put low byte or halfword on mirrored lanes.
`include "lmp_defines.vh"

module lmp_master (
  clock,
  sys_rst,
  bigEndian,
  reqValid,
  reqWrite,
  reqSize,
  reqAddr,
  reqData,
  reqReady,
  rspValid,
  rspData,
  rspFixedErr,
  rspBadWord,
  rspMisalign,
  dataAccepted,
  dataAddr,
  laneSel,
  writeData,
  dataSideStartStrobe,
  readStrobe,
  writeStrobe,
  readData,
  dataSideDone,
  dataSideHold,
  dataFixedErrFlag,
  dataBadWordFlag,
  fetchValid,
  fetchAddr,
  fetchReady,
  fetchRspValid,
  fetchRspWord,
  fetchRspFixedErr,
  fetchRspBadWord,
  instrAddr,
  instrSideStartStrobe,
  fetchBusyFlag,
  instrWord,
  instrSideDone,
  instrSideHold,
  instrFixedErrFlag,
  instrBadWordFlag
);
  input wire clock;
  input wire sys_rst;
  input wire bigEndian;
  input wire reqValid;
  input wire reqWrite;
  input wire [1:0] reqSize;
  input wire [0:31] reqAddr;
  input wire [0:31] reqData;
  output wire reqReady;
  output wire rspValid;
  output wire [0:31] rspData;
  output wire rspFixedErr;
  output wire rspBadWord;
  output wire rspMisalign;
  output wire dataAccepted;
  output wire [0:31] dataAddr;
  output wire [0:3] laneSel;
  output wire [0:31] writeData;
  output wire dataSideStartStrobe;
  output wire readStrobe;
  output wire writeStrobe;
  input wire [0:31] readData;
  input wire dataSideDone;
  input wire dataSideHold;
  input wire dataFixedErrFlag;
  input wire dataBadWordFlag;
  input wire fetchValid;
  input wire [0:31] fetchAddr;
  output wire fetchReady;
  output wire fetchRspValid;
  output wire [0:31] fetchRspWord;
  output wire fetchRspFixedErr;
  output wire fetchRspBadWord;
  output wire [0:31] instrAddr;
  output wire instrSideStartStrobe;
  output wire fetchBusyFlag;
  input wire [0:31] instrWord;
  input wire instrSideDone;
  input wire instrSideHold;
  input wire instrFixedErrFlag;
  input wire instrBadWordFlag;

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;

  // alignment check: halfwords on even, words on word boundaries
  function misaligned;
    input [1:0] size;
    input [1:0] low;
    begin
      case (size)
        `LMP_SZ_BYTE: misaligned = 1'b0;
        `LMP_SZ_HALF: misaligned = low[0];
        `LMP_SZ_WORD: misaligned = (low != 2'h0);
        default: misaligned = 1'b1;
      endcase
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] size_r;
  reg [1:0] addrLow_r;
  reg endian_r;
  reg [0:31] dataAddr_r;
  reg [0:3] laneSel_r;
  reg [0:31] writeData_r;
  reg startStrobe_r;
  reg readStrobe_r;
  reg writeStrobe_r;
  reg rspValid_r;
  reg [0:31] rspData_r;
  reg rspFixedErr_r;
  reg rspBadWord_r;
  reg rspMisalign_r;
  reg accepted_r;

  wire busy;
  wire doneNow;
  wire take;
  wire badAlign;
  wire issue;
  wire [0:3] reqLanes;
  wire [0:31] reqLaneData;
  wire [0:31] loadVal;

  // request-side lane steering for the store being issued
  lmp_steer u_store_steer (
    .bigEndian(bigEndian),
    .size(reqSize),
    .addrLow(reqAddr[30:31]),
    .storeVal(reqData),
    .loadWord(`LMP_RST_DATA),
    .laneSel(reqLanes),
    .laneData(reqLaneData),
    .loadVal()
  );

  // completion-side steering, from the transfer's captured attributes
  lmp_steer u_load_steer (
    .bigEndian(endian_r),
    .size(size_r),
    .addrLow(addrLow_r),
    .storeVal(`LMP_RST_DATA),
    .loadWord(readData),
    .laneSel(),
    .laneData(),
    .loadVal(loadVal)
  );

  lmp_fetch u_fetch (
    .clock(clock),
    .sys_rst(sys_rst),
    .fetchValid(fetchValid),
    .fetchAddr(fetchAddr),
    .fetchReady(fetchReady),
    .fetchRspValid(fetchRspValid),
    .fetchRspWord(fetchRspWord),
    .fetchRspFixedErr(fetchRspFixedErr),
    .fetchRspBadWord(fetchRspBadWord),
    .instrAddr(instrAddr),
    .instrSideStartStrobe(instrSideStartStrobe),
    .fetchBusyFlag(fetchBusyFlag),
    .instrWord(instrWord),
    .instrSideDone(instrSideDone),
    .instrSideHold(instrSideHold),
    .instrFixedErrFlag(instrFixedErrFlag),
    .instrBadWordFlag(instrBadWordFlag)
  );

  assign busy = (state_r != ST_IDLE);
  assign doneNow = busy && dataSideDone;
  // a new request may be taken on the very edge that completes the old one
  // a refusal waits for idle, so its pulse never merges with a completion
  assign reqReady = !busy || (dataSideDone && !badAlign);
  assign take = reqValid && reqReady;
  assign badAlign = misaligned(reqSize, reqAddr[30:31]);
  assign issue = take && !badAlign;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (issue) begin
          state_nxt = reqWrite ? ST_WRITE : ST_READ;
        end
      end
      ST_READ, ST_WRITE: begin
        if (dataSideDone) begin
          if (issue) begin
            state_nxt = reqWrite ? ST_WRITE : ST_READ;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      size_r <= `LMP_SZ_WORD;
      addrLow_r <= 2'h0;
      endian_r <= 1'b1;
      dataAddr_r <= `LMP_RST_ADDR;
      laneSel_r <= `LMP_LANE_NONE;
      writeData_r <= `LMP_RST_DATA;
      startStrobe_r <= 1'b0;
      readStrobe_r <= 1'b0;
      writeStrobe_r <= 1'b0;
      accepted_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      startStrobe_r <= issue;
      if (issue) begin
        dataAddr_r <= reqAddr;
        laneSel_r <= reqLanes;
        writeData_r <= reqWrite ? reqLaneData : `LMP_RST_DATA;
        size_r <= reqSize;
        addrLow_r <= reqAddr[30:31];
        endian_r <= bigEndian;
      end
      // strobes follow the state; back-to-back transfers of the same kind keep them high
      readStrobe_r <= (state_nxt == ST_READ);
      writeStrobe_r <= (state_nxt == ST_WRITE);
      if (issue || doneNow) begin
        accepted_r <= 1'b0;
      end else if (busy && dataSideHold) begin
        accepted_r <= 1'b1;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      rspValid_r <= 1'b0;
      rspData_r <= `LMP_RST_DATA;
      rspFixedErr_r <= 1'b0;
      rspBadWord_r <= 1'b0;
      rspMisalign_r <= 1'b0;
    end else begin
      rspValid_r <= doneNow || (take && badAlign);
      rspMisalign_r <= take && badAlign;
      if (doneNow) begin
        if (state_r == ST_READ) begin
          rspData_r <= loadVal;
        end
        rspFixedErr_r <= dataFixedErrFlag;
        rspBadWord_r <= dataBadWordFlag;
      end else if (take && badAlign) begin
        rspFixedErr_r <= 1'b0;
        rspBadWord_r <= 1'b0;
      end
    end
  end

  assign dataAddr = dataAddr_r;
  assign laneSel = laneSel_r;
  assign writeData = writeData_r;
  assign dataSideStartStrobe = startStrobe_r;
  assign readStrobe = readStrobe_r;
  assign writeStrobe = writeStrobe_r;
  assign rspValid = rspValid_r;
  assign rspData = rspData_r;
  assign rspFixedErr = rspFixedErr_r;
  assign rspBadWord = rspBadWord_r;
  assign rspMisalign = rspMisalign_r;
  assign dataAccepted = accepted_r;
endmodule // lmp_master

//--- tb/lmp_master_assertions.sv
// protocol checker for the local bus master port
// assumes binding to lmp_master and one core clock
module lmp_master_checker (
  input wire clock,
  input wire sys_rst,
  input wire reqValid,
  input wire reqReady,
  input wire [1:0] reqSize,
  input wire [0:31] reqAddr,
  input wire rspValid,
  input wire rspMisalign,
  input wire rspFixedErr,
  input wire rspBadWord,
  input wire [0:31] dataAddr,
  input wire [0:3] laneSel,
  input wire dataSideStartStrobe,
  input wire readStrobe,
  input wire writeStrobe,
  input wire dataSideDone,
  input wire dataFixedErrFlag,
  input wire dataBadWordFlag,
  input wire [0:31] instrAddr,
  input wire instrSideStartStrobe,
  input wire fetchBusyFlag,
  input wire instrSideDone
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_busyOpen;
    (readStrobe || writeStrobe) && !dataSideDone;
  endsequence
  sequence s_busyEnd;
    (readStrobe || writeStrobe) && dataSideDone;
  endsequence
  property p_startAlone;
    s_busyOpen |=> !dataSideStartStrobe;
  endproperty
  a_startAlone: assert property (p_startAlone) else $error("start inside open transfer");
  property p_addr;
    dataSideStartStrobe |-> dataAddr == $past(reqAddr);
  endproperty
  a_addr: assert property (p_addr) else $error("address not the requested one");
  property p_lanes;
    dataSideStartStrobe |-> laneSel inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes) else $error("illegal lane pattern");
  property p_kind;
    dataSideStartStrobe |-> readStrobe != writeStrobe;
  endproperty
  a_kind: assert property (p_kind) else $error("start without one strobe");
  property p_readHold;
    readStrobe && !dataSideDone |=> readStrobe;
  endproperty
  a_readHold: assert property (p_readHold) else $error("read strobe dropped early");
  property p_readEnd;
    readStrobe && dataSideDone |=> readStrobe == (dataSideStartStrobe && !writeStrobe);
  endproperty
  a_readEnd: assert property (p_readEnd) else $error("read strobe wrong after done");
  property p_writeEnd;
    writeStrobe && dataSideDone |=> writeStrobe == (dataSideStartStrobe && !readStrobe);
  endproperty
  a_writeEnd: assert property (p_writeEnd) else $error("write strobe wrong after done");
  property p_rsp;
    s_busyEnd |=> rspValid && !rspMisalign;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no response after done");
  property p_err;
    s_busyEnd ##1 rspValid |-> rspFixedErr == $past(dataFixedErrFlag)
      && rspBadWord == $past(dataBadWordFlag);
  endproperty
  a_err: assert property (p_err) else $error("error flags not passed on");
  property p_refuse;
    reqValid && reqReady && reqSize == 2'h3 && !readStrobe && !writeStrobe
      |=> rspValid && rspMisalign && !dataSideStartStrobe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad size not refused");
  property p_fetch;
    instrSideStartStrobe |-> fetchBusyFlag && instrAddr[30:31] == 2'h0;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch start malformed");
  property p_fetchHold;
    fetchBusyFlag && !instrSideDone |=> fetchBusyFlag && !instrSideStartStrobe;
  endproperty
  a_fetchHold: assert property (p_fetchHold) else $error("fetch busy dropped early");
endmodule // lmp_master_checker

bind lmp_master lmp_master_checker u_chk (.clock, .sys_rst, .reqValid, .reqReady, .reqSize,
  .reqAddr, .rspValid, .rspMisalign, .rspFixedErr, .rspBadWord, .dataAddr, .laneSel,
  .dataSideStartStrobe, .readStrobe, .writeStrobe, .dataSideDone, .dataFixedErrFlag,
  .dataBadWordFlag, .instrAddr, .instrSideStartStrobe, .fetchBusyFlag, .instrSideDone);

//--- tb/lmp_mem_model.sv
// local memory model answering after a set number of wait cycles
// assumes one transfer at a time and the core clock
module lmp_mem_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] waits,
  input wire logic fixErr,
  input wire logic badErr,
  input wire logic start,
  input wire logic wrStb,
  input wire logic [0:31] addr,
  input wire logic [0:3] lanes,
  input wire logic [0:31] wdata,
  output logic [0:31] rdata,
  output logic done,
  output logic hold,
  output logic fixFlag,
  output logic badFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [0:31] mem [16];
  logic [0:31] addr_r, wd_r, a, wd;
  logic [0:3] ln_r, ln;
  logic [3:0] cnt_r, left;
  logic pend_r, act;
  initial for (int i = 0; i < 16; i++) mem[i] = {8{i[3:0]}};
  assign act = start | pend_r;
  assign left = start ? waits : cnt_r;
  assign a = start ? addr : addr_r;
  assign ln = start ? lanes : ln_r;
  assign wd = start ? wdata : wd_r;
  assign done = act && left == 4'h0;
  assign hold = act && left != 4'h0;
  assign fixFlag = done && fixErr;
  assign badFlag = done && badErr;
  // released bus shows the inverse word
  assign rdata = done ? mem[a[26:29]] : ~mem[a[26:29]];
  always @(posedge clock) begin
    if (start) begin
      addr_r <= addr;
      ln_r <= lanes;
      wd_r <= wdata;
    end
    pend_r <= !sys_rst && hold;
    cnt_r <= left - 4'h1;
    if (done && wrStb)
      for (int k = 0; k < 4; k++)
        if (ln[k]) mem[a[26:29]][8*k +: 8] <= wd[8*k +: 8];
  end
endmodule // lmp_mem_model

//--- tb/test_lmp_master.sv
// self-checking bench for the local bus master port
// assumes the memory model and the bound checker
module test_lmp_master;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, bigEndian, reqValid, reqWrite, fetchValid, fe, be;
  logic [1:0] reqSize;
  logic [3:0] waits;
  logic [0:3] laneSel;
  logic [0:31] reqAddr, reqData, fetchAddr, rspData, dataAddr, writeData, readData;
  logic [0:31] fetchRspWord, instrAddr, instrWord;
  logic reqReady, rspValid, rspFixedErr, rspBadWord, rspMisalign, dataAccepted;
  logic dataSideStartStrobe, readStrobe, writeStrobe, dataSideDone, dataSideHold;
  logic dataFixedErrFlag, dataBadWordFlag, fetchReady, fetchRspValid, fetchRspFixedErr;
  logic fetchRspBadWord, instrSideStartStrobe, fetchBusyFlag, instrSideDone, instrSideHold;
  logic instrFixedErrFlag, instrBadWordFlag, acc;
  int bad_count = 0;
  int cmp_count = 0;
  logic [0:34] rq[$];
  logic [0:3] lq[$];
  lmp_master u_dut (.*);
  lmp_mem_model u_dmem (.clock(clock), .sys_rst(sys_rst), .waits(waits), .fixErr(fe),
    .badErr(be), .start(dataSideStartStrobe), .wrStb(writeStrobe), .addr(dataAddr),
    .lanes(laneSel), .wdata(writeData), .rdata(readData), .done(dataSideDone),
    .hold(dataSideHold), .fixFlag(dataFixedErrFlag), .badFlag(dataBadWordFlag));
  lmp_mem_model u_imem (.clock(clock), .sys_rst(sys_rst), .waits(waits), .fixErr(fe),
    .badErr(be), .start(instrSideStartStrobe), .wrStb(1'b0), .addr(instrAddr),
    .lanes(4'hf), .wdata(32'h0), .rdata(instrWord), .done(instrSideDone),
    .hold(instrSideHold), .fixFlag(instrFixedErrFlag), .badFlag(instrBadWordFlag));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(negedge clock) begin
    if (rspValid === 1'b1) rq.push_back({rspFixedErr, rspBadWord, rspMisalign, rspData});
    if (dataSideStartStrobe === 1'b1) lq.push_back(laneSel);
    if (dataSideDone === 1'b1) acc <= dataAccepted;
  end
  task automatic stop_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [0:34] got, input logic [0:34] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic until_hi(input int sel);
    int n;
    n = 0;
    @(negedge clock);
    while ((sel == 0 ? reqReady : (sel == 1 ? fetchReady : fetchRspValid)) !== 1'b1) begin
      n++;
      if (n > 40) begin
        bad_count++;
        stop_test();
      end
      @(negedge clock);
    end
  endtask
  task automatic issue(input logic w, input logic [1:0] sz, input logic [0:31] a, d);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSize <= sz;
    reqAddr <= a;
    reqData <= d;
    until_hi(0);
    @(posedge clock);
  endtask
  task automatic resp(output logic [0:34] r);
    int n;
    n = 0;
    while (rq.size() == 0) begin
      n++;
      if (n > 40) begin
        bad_count++;
        stop_test();
      end
      @(posedge clock);
    end
    r = rq.pop_front();
  endtask
  task automatic xfer(input logic w, input logic [1:0] sz, input logic [0:31] a, d,
      output logic [0:34] r);
    issue(w, sz, a, d);
    reqValid <= 1'b0;
    resp(r);
  endtask
  task automatic t_steer;
    logic [0:34] r;
    logic [0:31] w, v, m;
    logic [0:3] ln;
    int ls, sh;
    w = 32'h11223344;
    xfer(1'b1, 2'h2, 32'h10, w, r);
    xfer(1'b0, 2'h2, 32'h10, 32'h0, r);
    chk(r, {3'h0, w});
    for (int s = 0; s < 2; s++)
      for (int e = 0; e < 2; e++)
        for (int a = 0; a < 4; a += s + 1) begin
          bigEndian <= e[0];
          ls = e ? a : (s ? 2 - a : 3 - a);
          sh = 8 * (3 - s - ls);
          m = s ? 32'hffff : 32'hff;
          ln = (s ? 4'hc : 4'h8) >> ls;
          v = (32'ha5c3 + a * 32'h1111 + e) & m;
          lq.delete();
          xfer(1'b1, s[1:0], 32'h10 + a, v, r);
          w = (w & ~(m << sh)) | (v << sh);
          xfer(1'b0, s[1:0], 32'h10 + a, 32'h0, r);
          chk(r, {3'h0, v});
          chk({27'h0, lq[0], lq[1]}, {27'h0, ln, ln});
          xfer(1'b0, 2'h2, 32'h10, 32'h0, r);
          chk(r, {3'h0, w});
        end
    bigEndian <= 1'b1;
  endtask
  task automatic t_b2b;
    logic [0:34] r;
    issue(1'b0, 2'h2, 32'h4, 32'h0);
    issue(1'b0, 2'h2, 32'h8, 32'h0);
    issue(1'b1, 2'h2, 32'hc, 32'h0);
    issue(1'b1, 2'h2, 32'hc, 32'h99);
    reqValid <= 1'b0;
    resp(r);
    chk(r, {3'h0, 32'h11111111});
    resp(r);
    chk(r, {3'h0, 32'h22222222});
    resp(r);
    resp(r);
    xfer(1'b0, 2'h2, 32'hc, 32'h0, r);
    chk(r, {3'h0, 32'h99});
    chk({34'h0, acc}, 35'h0);
  endtask
  task automatic t_err;
    logic [0:34] r;
    waits <= 4'h3;
    fe <= 1'b1;
    xfer(1'b0, 2'h2, 32'h14, 32'h0, r);
    chk(r, {3'h4, 32'h55555555});
    chk({34'h0, acc}, 35'h1);
    fe <= 1'b0;
    be <= 1'b1;
    xfer(1'b1, 2'h0, 32'h17, 32'h0, r);
    chk(r, {3'h2, 32'h55555555});
    lq.delete();
    be <= 1'b0;
    waits <= 4'h0;
    for (int k = 1; k < 4; k++) begin
      xfer(1'b0, k[1:0], k, 32'h0, r);
      chk({32'h0, r[0:2]}, 35'h1);
    end
    chk(35'(lq.size()), 35'h0);
  endtask
  task automatic t_fetch;
    waits <= 4'h1;
    be <= 1'b1;
    fetchAddr <= 32'h1e;
    fetchValid <= 1'b1;
    until_hi(1);
    @(posedge clock);
    fetchValid <= 1'b0;
    until_hi(2);
    chk({fetchRspFixedErr, fetchRspBadWord, 1'b0, fetchRspWord}, {3'h2, 32'h77777777});
    @(posedge clock);
    be <= 1'b0;
    waits <= 4'h0;
  endtask
  initial begin
    sys_rst = 1'b1;
    bigEndian = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqSize = 2'h0;
    reqAddr = 32'h0;
    reqData = 32'h0;
    fetchValid = 1'b0;
    fetchAddr = 32'h0;
    waits = 4'h0;
    fe = 1'b0;
    be = 1'b0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_steer();
    $display("steering test done");
    t_b2b();
    $display("back-to-back test done");
    t_err();
    $display("wait and error test done");
    t_fetch();
    $display("fetch test done");
    stop_test();
  end
endmodule // test_lmp_master
